// [core/dmlc_pkg.sv]
package dmlc_pkg;

    // ************************************************
    // bus geometry
    // ************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 10;

    // ************************************************
    // register indices; byte address is four times the index
    // ************************************************
    localparam logic [IDX_W-1:0] IDX_DITHER = 10'h09D;
    localparam logic [IDX_W-1:0] IDX_MARKER = 10'h160;
    localparam logic [IDX_W-1:0] IDX_LINK_EN = 10'h200;
    localparam logic [IDX_W-1:0] IDX_MODE = 10'h201;
    localparam logic [IDX_W-1:0] IDX_AUX = 10'h300;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h301;
    localparam logic [1:0] BYTE_LANE0 = 2'h0;

    // ************************************************
    // field positions and widths
    // ************************************************
    localparam int DITH_EN_BIT = 0;
    localparam int DITH_AMP_BIT = 1;
    localparam int DITH_ERR_BIT = 2;
    localparam int DITH_W = 3;
    localparam int MARKER_EN_BIT = 0;
    localparam int LINK_EN_BIT = 0;
    localparam int MODE_W = 6;
    localparam int CAL_EN_BIT = 0;
    localparam int RECV_EN_BIT = 1;
    localparam int AUX_W = 2;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_LMFC_LSB = 8;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [DITH_W-1:0] RST_DITHER = 3'h0;
    localparam logic RST_MARKER = 1'b0;
    localparam logic RST_LINK_EN = 1'b1;
    localparam logic [MODE_W-1:0] RST_MODE = 6'h00;
    localparam logic [AUX_W-1:0] RST_AUX = 2'h0;

    // ************************************************
    // bus responses
    // ************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // sample path and link framing
    // ************************************************
    localparam int ADC_W = 12;
    localparam int LINK_W = 16;
    localparam int PIPE_DEPTH = 4;
    localparam int CS_W = 2;
    localparam logic [CS_W-1:0] ILA_CS = 2'h0;
    localparam int LMFC_W = 5;
    localparam logic [LMFC_W-1:0] LMFC_LAST = 5'h1F;
    localparam logic [LMFC_W-1:0] LMFC_ZERO = 5'h00;
    localparam logic [LMFC_W-1:0] LMFC_ONE = 5'h01;

endpackage

// [core/dmlc_delay.sv]
// fixed-depth delay line shared by sample and marker paths
module dmlc_delay
    import dmlc_pkg::*;
#(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ************************************************
    // shift stages
    // ************************************************
    logic [WIDTH-1:0] stage_q [DEPTH];
    logic [WIDTH-1:0] stage_d [DEPTH];

    // next values: stage 0 takes din, each later stage takes its predecessor
    always_comb begin
        stage_d[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            stage_d[i] = stage_q[i-1];
        end
    end

    // register the stages
    always_ff @(posedge aclk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!aresetn) begin
                stage_q[i] <= '0;
            end else begin
                stage_q[i] <= stage_d[i];
            end
        end
    end

    assign dout = stage_q[DEPTH-1];

endmodule

// [core/dmlc_top.sv]
module dmlc_top
    import dmlc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter core controls
    output logic dither_enable_bit,
    output logic dither_amplitude_select,
    output logic dither_rounding_select,
    output logic cal_enable,
    output logic marker_receiver_enable,
    // sample path
    input wire logic [ADC_W-1:0] adc_sample,
    input wire logic timestamp_in,
    output logic [LINK_W-1:0] link_sample,
    output logic [CS_W-1:0] ila_control_bits,
    // link subsystem controls
    input wire logic sysref,
    output logic [MODE_W-1:0] link_output_mode,
    output logic link_reset_n,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic [LMFC_W-1:0] lmfc_count
);

    // ************************************************
    // state
    // ************************************************
    logic aw_full_q, aw_full_d;
    logic [IDX_W-1:0] aw_idx_q, aw_idx_d;
    logic w_full_q, w_full_d;
    logic [REG_W-1:0] wdata_q, wdata_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [DITH_W-1:0] dither_q, dither_d;
    logic marker_en_q, marker_en_d;
    logic link_en_q, link_en_d;
    logic [MODE_W-1:0] mode_q, mode_d;
    logic [AUX_W-1:0] aux_q, aux_d;
    logic [LMFC_W-1:0] lmfc_q, lmfc_d;
    logic [LINK_W-1:0] sample_q, sample_d;

    logic do_write;
    logic wr_hit;
    logic [IDX_W-1:0] ar_idx;
    logic rd_hit;
    logic [DATA_W-1:0] rd_word;
    logic [ADC_W:0] dly_in;
    logic [ADC_W:0] dly_out;

    // ************************************************
    // channel handshakes
    // ************************************************
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !rvalid_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];

    // write address decode
    always_comb begin
        case (aw_idx_q)
            IDX_DITHER, IDX_MARKER, IDX_LINK_EN, IDX_MODE, IDX_AUX: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (ar_idx)
            IDX_DITHER: begin
                rd_word[DITH_W-1:0] = dither_q;
            end
            IDX_MARKER: begin
                rd_word[MARKER_EN_BIT] = marker_en_q;
            end
            IDX_LINK_EN: begin
                rd_word[LINK_EN_BIT] = link_en_q;
            end
            IDX_MODE: begin
                rd_word[MODE_W-1:0] = mode_q;
            end
            IDX_AUX: begin
                rd_word[AUX_W-1:0] = aux_q;
            end
            IDX_STATUS: begin
                rd_word[STAT_ACTIVE_BIT] = link_en_q;
                rd_word[STAT_LMFC_LSB +: LMFC_W] = lmfc_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ************************************************
    // bus and register next values
    // ************************************************
    always_comb begin
        aw_full_d = aw_full_q;
        aw_idx_d = aw_idx_q;
        w_full_d = w_full_q;
        wdata_d = wdata_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        dither_d = dither_q;
        marker_en_d = marker_en_q;
        link_en_d = link_en_q;
        mode_d = mode_q;
        aux_d = aux_q;

        // address and data may arrive in either order
        if (s_axi_awvalid && !aw_full_q) begin
            aw_full_d = 1'b1;
            aw_idx_d = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && !w_full_q) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata[REG_W-1:0];
            wlane_d = s_axi_wstrb[BYTE_LANE0];
        end

        // response leaves once taken
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end

        // commit once both halves are held and no response is pending; only defined bits are kept
        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (wlane_q) begin
                case (aw_idx_q)
                    IDX_DITHER: begin
                        dither_d = wdata_q[DITH_W-1:0];
                    end
                    IDX_MARKER: begin
                        marker_en_d = wdata_q[MARKER_EN_BIT];
                    end
                    IDX_LINK_EN: begin
                        link_en_d = wdata_q[LINK_EN_BIT];
                    end
                    IDX_MODE: begin
                        mode_d = wdata_q[MODE_W-1:0];
                    end
                    IDX_AUX: begin
                        aux_d = wdata_q[AUX_W-1:0];
                    end
                    default: begin
                        aux_d = aux_q;
                    end
                endcase
            end
        end

        // read answer one cycle after the address is taken
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // register bus and control state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_idx_q <= '0;
            w_full_q <= 1'b0;
            wdata_q <= '0;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
            dither_q <= RST_DITHER;
            marker_en_q <= RST_MARKER;
            link_en_q <= RST_LINK_EN;
            mode_q <= RST_MODE;
            aux_q <= RST_AUX;
        end else begin
            aw_full_q <= aw_full_d;
            aw_idx_q <= aw_idx_d;
            w_full_q <= w_full_d;
            wdata_q <= wdata_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            dither_q <= dither_d;
            marker_en_q <= marker_en_d;
            link_en_q <= link_en_d;
            mode_q <= mode_d;
            aux_q <= aux_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ************************************************
    // converter core controls
    // ************************************************
    assign dither_enable_bit = dither_q[DITH_EN_BIT];
    assign dither_amplitude_select = dither_q[DITH_AMP_BIT];
    assign dither_rounding_select = dither_q[DITH_ERR_BIT];
    assign cal_enable = aux_q[CAL_EN_BIT];
    assign marker_receiver_enable = aux_q[RECV_EN_BIT];
    assign link_output_mode = mode_q;

    // ************************************************
    // link gating
    // ************************************************
    assign link_reset_n = link_en_q;
    assign serializer_power_down = !link_en_q;
    assign link_clock_enable = link_en_q;

    // ************************************************
    // multiframe counter
    // ************************************************
    always_comb begin
        if (!link_en_q) begin
            lmfc_d = LMFC_ZERO;
        end else if (sysref) begin
            lmfc_d = LMFC_ZERO;
        end else if (lmfc_q == LMFC_LAST) begin
            lmfc_d = LMFC_ZERO;
        end else begin
            lmfc_d = lmfc_q + LMFC_ONE;
        end
    end

    // register the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lmfc_q <= LMFC_ZERO;
        end else begin
            lmfc_q <= lmfc_d;
        end
    end

    assign lmfc_count = lmfc_q;

    // ************************************************
    // sample path with marker insertion
    // ************************************************
    assign dly_in = {adc_sample, timestamp_in};

    // sample and marker travel the same stages
    dmlc_delay #(
        .WIDTH(ADC_W + 1),
        .DEPTH(PIPE_DEPTH)
    ) u_align (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(dly_in),
        .dout(dly_out)
    );

    // left-justify the converter word; bit 0 of the field holds the marker
    always_comb begin
        sample_d = '0;
        if (link_en_q) begin
            sample_d[LINK_W-1 -: ADC_W] = dly_out[ADC_W:1];
            sample_d[0] = marker_en_q && dly_out[0];
        end
    end

    // register the outgoing sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_q <= '0;
        end else begin
            sample_q <= sample_d;
        end
    end

    assign link_sample = sample_q;
    assign ila_control_bits = ILA_CS;

endmodule

// [test/dmlc_props.sv]
// ************************************************
// port checker
// ************************************************
module dmlc_props
    import dmlc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    // core and link
    input wire logic dither_enable_bit,
    input wire logic dither_amplitude_select,
    input wire logic dither_rounding_select,
    input wire logic [ADC_W-1:0] adc_sample,
    input wire logic [LINK_W-1:0] link_sample,
    input wire logic [CS_W-1:0] ila_control_bits,
    input wire logic sysref,
    input wire logic [MODE_W-1:0] link_output_mode,
    input wire logic link_reset_n,
    input wire logic serializer_power_down,
    input wire logic link_clock_enable,
    input wire logic [LMFC_W-1:0] lmfc_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] en_cnt_q;
    logic [2:0] en_cnt_d;
    // cycles the link has been up, saturating
    always_comb begin
        en_cnt_d = en_cnt_q;
        if (!link_reset_n) begin
            en_cnt_d = 3'h0;
        end else if (en_cnt_q != 3'h7) begin
            en_cnt_d = en_cnt_q + 3'h1;
        end
    end
    always_ff @(posedge aclk) begin
        en_cnt_q <= aresetn ? en_cnt_d : 3'h0;
    end
    property p_ila; ila_control_bits == ILA_CS; endproperty
    a_ila: assert property (p_ila) else $error("lane alignment control bits not zero");
    property p_gate; serializer_power_down == !link_reset_n && link_clock_enable == link_reset_n; endproperty
    a_gate: assert property (p_gate) else $error("link gating outputs disagree");
    property p_hold; !link_reset_n && $past(!link_reset_n) |-> lmfc_count == LMFC_ZERO; endproperty
    a_hold: assert property (p_hold) else $error("counter runs while link off");
    property p_count;
        link_reset_n && $past(link_reset_n) && $past(link_reset_n, 2) && $past(aresetn) && !$past(sysref)
            |-> lmfc_count == $past(lmfc_count) + LMFC_ONE;
    endproperty
    a_count: assert property (p_count) else $error("counter step wrong");
    property p_off; !link_reset_n && $past(!link_reset_n) |-> link_sample == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("samples leave a disabled link");
    property p_gap; link_sample[LINK_W-ADC_W-1:1] == 3'h0; endproperty
    a_gap: assert property (p_gap) else $error("pad bits not zero");
    property p_lat; en_cnt_q == 3'h7 |-> link_sample[LINK_W-1 -: ADC_W] == $past(adc_sample, 5); endproperty
    a_lat: assert property (p_lat) else $error("sample latency wrong");
    property p_rst;
        aresetn && !$past(aresetn) |-> !dither_enable_bit && !dither_amplitude_select
            && !dither_rounding_select && link_reset_n && link_output_mode == RST_MODE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_dith; $changed({dither_enable_bit, dither_amplitude_select, dither_rounding_select}) |-> $rose(s_axi_bvalid); endproperty
    a_dith: assert property (p_dith) else $error("dither bits moved without a write");
    property p_mode; $changed(link_output_mode) |-> $rose(s_axi_bvalid); endproperty
    a_mode: assert property (p_mode) else $error("mode moved without a write");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
endmodule

bind dmlc_top dmlc_props props_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
    .dither_enable_bit, .dither_amplitude_select, .dither_rounding_select, .adc_sample, .link_sample,
    .ila_control_bits, .sysref, .link_output_mode, .link_reset_n, .serializer_power_down, .link_clock_enable,
    .lmfc_count);

// [test/dmlc_top_tb_top.sv]
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
// ************************************************
// bench top
// ************************************************
module dmlc_top_tb_top
    import dmlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timestamp_in = 1'b0, sysref = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [ADC_W-1:0] adc_sample = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dither_enable_bit;
    logic dither_amplitude_select, dither_rounding_select, cal_enable, marker_receiver_enable;
    logic link_reset_n, serializer_power_down, link_clock_enable;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [LINK_W-1:0] link_sample;
    logic [CS_W-1:0] ila_control_bits;
    logic [MODE_W-1:0] link_output_mode;
    logic [LMFC_W-1:0] lmfc_count;
    int failures = 0, compares = 0, cycles = 0;
    dmlc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dither_enable_bit,
        .dither_amplitude_select, .dither_rounding_select, .cal_enable, .marker_receiver_enable, .adc_sample,
        .timestamp_in, .link_sample, .ila_control_bits, .sysref, .link_output_mode, .link_reset_n,
        .serializer_power_down, .link_clock_enable, .lmfc_count);
    // clock and hang guard
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ************************************************
    // bus tasks
    // ************************************************
    task automatic wchk(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, BYTE_LANE0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rchk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, BYTE_LANE0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset_vals();
        rchk(IDX_DITHER, 32'h00000000, RESP_OKAY);
        rchk(IDX_MARKER, 32'h00000000, RESP_OKAY);
        rchk(IDX_LINK_EN, 32'h00000001, RESP_OKAY);
        rchk(IDX_MODE, 32'h00000000, RESP_OKAY);
        rchk(IDX_AUX, 32'h00000000, RESP_OKAY);
        `CHK(ila_control_bits, ILA_CS)
        $display("test reset values done");
    endtask
    task automatic t_dither();
        for (int i = 0; i < 8; i++) begin
            wchk(IDX_DITHER, 8'(i), RESP_OKAY);
            `CHK({dither_rounding_select, dither_amplitude_select, dither_enable_bit}, 3'(i))
            rchk(IDX_DITHER, 32'(i), RESP_OKAY);
        end
        $display("test dither done");
    endtask
    task automatic t_link();
        logic [MODE_W-1:0] modes[4] = '{6'h00, 6'h15, 6'h2A, 6'h3F};
        wchk(IDX_AUX, 8'h01, RESP_OKAY);
        `CHK(cal_enable, 1'b1)
        wchk(IDX_LINK_EN, 8'h00, RESP_OKAY);
        `CHK({link_reset_n, serializer_power_down, link_clock_enable}, 3'h2)
        @(posedge aclk);
        sysref <= 1'b1;
        repeat (3) @(posedge aclk);
        sysref <= 1'b0;
        `CHK(lmfc_count, LMFC_ZERO)
        rchk(IDX_STATUS, 32'h00000000, RESP_OKAY);
        wchk(IDX_AUX, 8'h00, RESP_OKAY);
        foreach (modes[i]) begin
            wchk(IDX_MODE, {2'h0, modes[i]}, RESP_OKAY);
            `CHK(link_output_mode, modes[i])
            rchk(IDX_MODE, {26'h0, modes[i]}, RESP_OKAY);
        end
        wchk(IDX_AUX, 8'h01, RESP_OKAY);
        wchk(IDX_LINK_EN, 8'h01, RESP_OKAY);
        `CHK({link_reset_n, serializer_power_down, link_clock_enable}, 3'h5)
        @(posedge aclk);
        sysref <= 1'b1;
        @(posedge aclk);
        sysref <= 1'b0;
        $display("test link done");
    endtask
    task automatic t_marker(input logic en);
        logic [LINK_W-1:0] exp_q[20];
        wchk(IDX_MARKER, {7'h00, en}, RESP_OKAY);
        wchk(IDX_AUX, {6'h00, en, 1'b1}, RESP_OKAY);
        `CHK({marker_receiver_enable, cal_enable}, {en, 1'b1})
        for (int i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (i >= 6) `CHK(link_sample, exp_q[i-6])
            adc_sample <= ADC_W'(i * 12'h2D3);
            timestamp_in <= i[0] ^ i[2];
            exp_q[i] = {ADC_W'(i * 12'h2D3), 3'h0, en & (i[0] ^ i[2])};
        end
        `CHK(ila_control_bits, ILA_CS)
        $display("test marker done");
    endtask
    task automatic t_unmapped();
        wchk(10'h3FF, 8'h5A, RESP_SLVERR);
        rchk(10'h3FF, 32'h00000000, RESP_SLVERR);
        wchk(IDX_STATUS, 8'h01, RESP_SLVERR);
        // lane 0 strobe clear: answered but nothing stored
        s_axi_wstrb <= 4'hE;
        wchk(IDX_DITHER, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rchk(IDX_DITHER, 32'h00000007, RESP_OKAY);
        $display("test unmapped done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_dither();
        t_link();
        t_marker(1'b1);
        t_marker(1'b0);
        t_unmapped();
        close_out();
    end
endmodule
